//--- verilog/ee_pkg.sv
// Shared constants, types and state codes for the serial memory slave port
package ee_pkg;

  // Array organisation
  localparam int unsigned MEM_DEPTH  = 256;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned FIFO_DEPTH = 16;

  // Clock and self-timed programming cycle, longest time rounds down
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned T_WR_MS       = 5;
  localparam int unsigned WR_CYCLES_DEF = (T_WR_MS * CLK_HZ) / 1000;
  localparam int unsigned WR_CNT_W      = 18;

  // Slave address byte layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam int unsigned RW_BIT       = 0;

  // Bit counter figures
  localparam logic [3:0] RX_LAST_BIT = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_RST     = 4'h0;

  // Values after reset
  localparam logic [7:0]  ADDR_RST  = 8'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [3:0]  PAGE_RST  = 4'h0;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [17:0] WRCNT_RST = 18'h00000;

  // Sampled pins travel together
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] dsel;
  } ee_pins_t;

  // Bus idles high, straps low
  localparam ee_pins_t PINS_RST = 6'h30;

  // One received write byte and where it goes
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ee_wr_entry_t;

  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100,
    ST_TXLD = 3'b101,
    ST_SKIP = 3'b110
  } ee_state_t;

  // Which byte of a transaction is being received
  typedef enum logic [1:0] {
    K_DEV  = 2'b00,
    K_ADDR = 2'b01,
    K_DATA = 2'b10
  } ee_kind_t;

endpackage

//--- verilog/ee_wr_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
module ee_wr_fifo
  import ee_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  // Extra pointer bit tells full from empty
  assign full        = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign empty       = (wptr_q == rptr_q);
  assign push        = in_valid_i && !full;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = store_q[rptr_q[AW-1:0]];

  // Pointers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else if (ce_i) begin
      if (push) wptr_q <= wptr_q + 1'b1;
      if (pop) rptr_q <= rptr_q + 1'b1;
    end
  end

  // Storage needs no reset, empty flag guards it
  always_ff @(posedge clk_i) begin
    if (ce_i && push) store_q[wptr_q[AW-1:0]] <= in_data_i;
  end

endmodule

//--- verilog/ee_slave_port.sv
// Two-wire slave port, page latch and self-timed array programming
module ee_slave_port
  import ee_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYCLES_DEF
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic device_select_bit0_i,
  input  wire logic device_select_bit1_i,
  input  wire logic device_select_bit2_i,
  input  wire logic wp_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      busy_o
);

  // Pin sampling
  wire ee_pins_t pins_raw;
  ee_pins_t      sync1_q;
  ee_pins_t      sync2_q;
  logic          scl_prev_q;
  logic          sda_prev_q;

  // Serial engine
  ee_state_t     state_q;
  ee_state_t     state_d;
  ee_kind_t      kind_q;
  ee_kind_t      kind_d;
  logic [3:0]    cnt_q;
  logic [3:0]    cnt_d;
  logic [7:0]    shreg_q;
  logic [7:0]    shreg_d;
  logic [7:0]    addr_q;
  logic [7:0]    addr_d;
  logic          rw_q;
  logic          rw_d;
  logic          oe_q;
  logic          oe_d;

  // Write path
  logic          pend_q;
  logic          commit_req_q;
  logic          busy_q;
  logic [17:0]   wr_cnt_q;
  logic [3:0]    page_q;
  logic [15:0]   mask_q;
  logic [7:0]    latch_q [PAGE_BYTES];
  logic [7:0]    mem_q   [MEM_DEPTH];
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  ee_wr_entry_t  fifo_out;

  // Sampled views and bus events
  wire           scl_s;
  wire           sda_s;
  wire           wp_s;
  wire [2:0]     dsel_s;
  wire           scl_rise;
  wire           scl_fall;
  wire           start_det;
  wire           stop_det;
  wire           byte_done;
  wire           dev_match;
  wire           byte_ack;
  wire           push;
  wire           pop;
  wire           commit_go;
  wire           do_prog;
  wire           abort_wr;
  wire           wr_done;
  wire [7:0]     mem_rd;
  ee_wr_entry_t  push_entry;

  // Pins come from outside the clock domain
  assign pins_raw = {scl_i, sda_i, wp_i,
                     device_select_bit2_i, device_select_bit1_i, device_select_bit0_i};

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_q <= PINS_RST;
      sync2_q <= PINS_RST;
    end else if (ce_i) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // Previous levels for edge finding
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce_i) begin
      scl_prev_q <= sync2_q.scl;
      sda_prev_q <= sync2_q.sda;
    end
  end

  // Serial clock edges time every bit; 40 MHz oversamples a 1 MHz bus
  assign scl_s     = sync2_q.scl;
  assign sda_s     = sync2_q.sda;
  assign wp_s      = sync2_q.wp;
  assign dsel_s    = sync2_q.dsel;
  assign scl_rise  = scl_s && !scl_prev_q;
  assign scl_fall  = !scl_s && scl_prev_q;
  assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // Byte decode; open select pads read low through the pad pull-down
  assign byte_done = (state_q == ST_RX) && scl_fall && (cnt_q == RX_LAST_BIT);
  assign dev_match = (shreg_q[7:4] == DEV_TYPE_CODE)
                   && (shreg_q[3:1] == dsel_s)
                   && !busy_q;
  assign byte_ack  = ((kind_q == K_DEV) && dev_match)
                   || (kind_q == K_ADDR)
                   || ((kind_q == K_DATA) && fifo_in_ready);
  assign push      = byte_done && (kind_q == K_DATA) && fifo_in_ready;
  assign push_entry = '{addr: addr_q, data: shreg_q};
  assign mem_rd    = mem_q[addr_q];

  // Next-state logic; start and stop override any bit in flight
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    cnt_d   = cnt_q;
    shreg_d = shreg_q;
    addr_d  = addr_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    if (start_det) begin
      state_d = ST_RX;
      kind_d  = K_DEV;
      cnt_d   = CNT_RST;
      oe_d    = 1'b0;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SKIP: begin
          oe_d = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && (cnt_q != RX_LAST_BIT)) begin
            shreg_d = {shreg_q[6:0], sda_s};
            cnt_d   = cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_d   = CNT_RST;
            state_d = byte_ack ? ST_ACK : ST_SKIP;
            oe_d    = byte_ack;
            unique case (kind_q)
              K_DEV:  rw_d = shreg_q[RW_BIT];
              K_ADDR: addr_d = shreg_q;
              K_DATA: begin
                if (fifo_in_ready) begin
                  addr_d = {addr_q[7:4], addr_q[3:0] + 4'h1};
                end
              end
              default: state_d = ST_SKIP;
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              shreg_d = mem_rd;
              oe_d    = !mem_rd[7];
              cnt_d   = CNT_RST;
              state_d = ST_TX;
            end else begin
              oe_d    = 1'b0;
              state_d = ST_RX;
              kind_d  = (kind_q == K_DEV) ? K_ADDR : K_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == TX_LAST_BIT) begin
              oe_d    = 1'b0;
              state_d = ST_MACK;
            end else begin
              shreg_d = {shreg_q[6:0], 1'b0};
              oe_d    = !shreg_q[6];
              cnt_d   = cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // Address moves on after every byte sent, acked or not
          if (scl_rise) begin
            addr_d  = addr_q + 8'h01;
            state_d = sda_s ? ST_SKIP : ST_TXLD;
          end
        end
        ST_TXLD: begin
          if (scl_fall) begin
            shreg_d = mem_rd;
            oe_d    = !mem_rd[7];
            cnt_d   = CNT_RST;
            state_d = ST_TX;
          end
        end
        default: begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  // Engine registers; reset drops everything back to standby
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      kind_q  <= K_DEV;
      cnt_q   <= CNT_RST;
      shreg_q <= BYTE_RST;
      addr_q  <= ADDR_RST;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      kind_q  <= kind_d;
      cnt_q   <= cnt_d;
      shreg_q <= shreg_d;
      addr_q  <= addr_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
    end
  end

  // Received bytes queue up on their way to the page latch
  ee_wr_fifo #(
    .WIDTH ($bits(ee_wr_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_entry),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!busy_q),
    .out_data_o  (fifo_out)
  );

  // Commit waits for the queue to drain so no byte is left behind
  assign pop       = fifo_out_valid && !busy_q;
  assign commit_go = commit_req_q && !fifo_out_valid;
  assign do_prog   = commit_go && !wp_s && rstn_i;
  assign abort_wr  = start_det && pend_q;
  assign wr_done   = busy_q && (wr_cnt_q == WR_CNT_W'(WR_CYCLES - 1));

  // Write bookkeeping and self-timed cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pend_q       <= 1'b0;
      commit_req_q <= 1'b0;
      busy_q       <= 1'b0;
      wr_cnt_q     <= WRCNT_RST;
    end else if (ce_i) begin
      if (push) pend_q <= 1'b1;
      else if (stop_det || abort_wr) pend_q <= 1'b0;
      if (stop_det && pend_q) commit_req_q <= 1'b1;
      else if (commit_go) commit_req_q <= 1'b0;
      if (do_prog) begin
        busy_q   <= 1'b1;
        wr_cnt_q <= WRCNT_RST;
      end else if (wr_done) begin
        busy_q   <= 1'b0;
      end else if (busy_q) begin
        wr_cnt_q <= wr_cnt_q + 18'h00001;
      end
    end
  end

  // Page row follows the queued bytes; high address bits hold in a page
  always_ff @(posedge clk_i) begin
    if (!rstn_i) page_q <= PAGE_RST;
    else if (ce_i && pop) page_q <= fifo_out.addr[7:4];
  end

  // Page latch: one byte and one valid bit per entry
  for (genvar e = 0; e < PAGE_BYTES; e++) begin : g_latch
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        latch_q[e] <= BYTE_RST;
        mask_q[e]  <= MASK_RST[e];
      end else if (ce_i) begin
        if (pop && (fifo_out.addr[3:0] == 4'(e))) begin
          latch_q[e] <= fifo_out.data;
          mask_q[e]  <= 1'b1;
        end else if (commit_go || abort_wr) begin
          mask_q[e]  <= 1'b0;
        end
      end
    end
  end

  // Array is nonvolatile: no reset, written only by a committed page
  for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
    always_ff @(posedge clk_i) begin
      if (ce_i && do_prog && (page_q == 4'(g / PAGE_BYTES))
          && mask_q[g % PAGE_BYTES]) begin
        mem_q[g] <= latch_q[g % PAGE_BYTES];
      end
    end
  end

  // Pad outputs; the level driven is always low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      busy_o   <= 1'b0;
    end else if (ce_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= oe_q;
      busy_o   <= busy_q;
    end
  end

endmodule

//--- dv/ee_slave_port_chk.sv
// Concurrent checks on the ports of the serial memory slave port
module ee_slave_port_chk
  import ee_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic device_select_bit0_i,
  input wire logic device_select_bit1_i,
  input wire logic device_select_bit2_i,
  input wire logic wp_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [WR_CNT_W-1:0] busy_cnt_q;
  logic [3:0]          fall_cnt_q;
  logic [3:0]          stop_cnt_q;
  logic                scl_q;
  logic                sda_q;
  wire logic           scl_fall;
  wire logic           stop_ev;

  // Pin events seen by one flop, early enough for the design's own sync
  assign scl_fall = scl_q & ~scl_i;
  assign stop_ev  = scl_i & sda_i & ~sda_q;

  // Edge counters saturate so a long idle never wraps into a false pass; the busy counter clears whenever busy is low
  always_ff @(posedge clk_i) begin
    scl_q      <= scl_i;
    sda_q      <= sda_i;
    busy_cnt_q <= (!rstn_i || !busy_o) ? WRCNT_RST : busy_cnt_q + 1'b1;
    fall_cnt_q <= scl_fall ? 4'h0 : (fall_cnt_q == 4'hF ? 4'hF : fall_cnt_q + 4'h1);
    stop_cnt_q <= stop_ev ? 4'h0 : (stop_cnt_q == 4'hF ? 4'hF : stop_cnt_q + 4'h1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_stop;
    scl_i && sda_i && !$past(sda_i);
  endsequence
  sequence s_quiet;
    !sda_oe_o [*8];
  endsequence

  a_pad_low: assert property (sda_o == 1'b0)
    else $error("pad output driven high");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn_i && ce_i |=> !sda_oe_o && !busy_o) else $error("outputs active in reset");
  a_busy_no_ack: assert property (busy_o |-> !sda_oe_o)
    else $error("line pulled while programming");
  a_oe_edge_time: assert property ($changed(sda_oe_o) |-> fall_cnt_q inside {[2:8]})
    else $error("line enable moved away from a clock fall");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("line enable moved while clock high");
  a_wp_no_prog: assert property (wp_i && $past(wp_i, 8) |-> !$rose(busy_o))
    else $error("programming started under protection");
  a_stop_idle: assert property (s_stop |=> s_quiet)
    else $error("line pulled after stop");
  a_busy_at_stop: assert property ($rose(busy_o) |-> stop_cnt_q <= 4'hC)
    else $error("programming started without stop");
  a_busy_len: assert property ($fell(busy_o) && $past(rstn_i)
    |-> busy_cnt_q >= WR_CYCLES - 1) else $error("programming cycle too short");
  a_busy_bound: assert property (busy_cnt_q <= WR_CYCLES)
    else $error("programming cycle too long");
endmodule

bind ee_slave_port ee_slave_port_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i),
  .device_select_bit0_i(device_select_bit0_i), .device_select_bit1_i(device_select_bit1_i),
  .device_select_bit2_i(device_select_bit2_i), .wp_i(wp_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .busy_o(busy_o));

//--- dv/ee_master.sv
// Behavioural two-wire bus master that makes the serial clock
module ee_master (
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_q;

  // Open-drain line with pull-up: released reads high
  assign sda_o = drv_q & ~sda_oe_i;

  initial begin
    scl_o = 1'b1;
    drv_q = 1'b1;
  end
  // Quarter bit of 10 clocks gives a 1 MHz serial clock
  task automatic q();
    repeat (10) @(negedge clk_i);
  endtask
  // Start, also a repeated start from clock low
  task automatic start();
    drv_q = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    drv_q = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic stop();
    drv_q = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    drv_q = 1'b1;
    q();
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    drv_q = b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_o;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // Byte MSB first, then the ninth slot driven with ack_in
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

//--- dv/ee_slave_port_tb.sv
// Self-checking bench for the serial memory slave port
module ee_slave_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WR_T = 600;  // Short programming time keeps the run brief
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] dsel = 3'h0;
  logic       wp = 1'b0;
  logic       scl;
  logic       sda;
  logic       pad;
  logic       oe;
  logic       busy;
  logic [7:0] rx;
  logic       ak;
  int         n;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         busy_len = 0;
  int         busy_last = 0;

  always #12.5 clk = ~clk;

  ee_slave_port #(.WR_CYCLES(WR_T)) dut (.clk_i(clk), .rstn_i(rstn), .ce_i(1'b1),
    .scl_i(scl), .sda_i(sda), .device_select_bit0_i(dsel[0]),
    .device_select_bit1_i(dsel[1]), .device_select_bit2_i(dsel[2]), .wp_i(wp),
    .sda_o(pad), .sda_oe_o(oe), .busy_o(busy));
  ee_master m (.clk_i(clk), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));

  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One byte, expecting ACK (0) or NACK (1) in the ninth slot
  task automatic put(input logic [7:0] b, input logic nack);
    m.xfer(b, 1'b1, rx, ak);
    chk(16'(ak), 16'(nack));
  endtask
  // Write header and data, stop left to the caller
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    m.start();
    put(8'hA0, 1'b0);
    put(a, 1'b0);
    foreach (d[i]) put(d[i], 1'b0);
  endtask
  // Dummy write of the pointer, repeated start, sequential read
  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    m.start();
    put(8'hA0, 1'b0);
    put(a, 1'b0);
    m.start();
    put(8'hA1, 1'b0);
    foreach (e[i]) begin
      m.xfer(8'hFF, i == e.size() - 1, rx, ak);
      chk(16'(rx), 16'(e[i]));
    end
    m.stop();
  endtask
  task automatic drain();
    for (n = 0; busy === 1'b1 && n < 900; n++) @(negedge clk);
  endtask
  // Busy must follow the stop and last the set time
  task automatic idle();
    repeat (20) if (busy !== 1'b1) @(negedge clk);
    chk(16'(busy), 16'h1);
    drain();
    @(negedge clk);
    chk(16'(busy_last), 16'(WR_T));
  endtask

  // Whole programming pulse in clocks; busy rises before idle can start counting
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      busy_last = busy_len;
      busy_len = 0;
    end
  end

  task automatic t_reset();
    chk(16'(oe), 16'h0);
    chk(16'(busy), 16'h0);
    chk(16'(pad), 16'h0);
  endtask
  task automatic t_select();
    for (int k = 0; k < 8; k++) begin
      dsel = 3'(k);
      m.start();
      put({4'hA, 3'(k), 1'b0}, 1'b0);
      m.start();
      put({4'hA, 3'(k) ^ 3'h4, 1'b0}, 1'b1);
      m.stop();
    end
    dsel = 3'h0;  // Open straps modelled as zero
  endtask
  task automatic t_page();
    logic [7:0] q[$];
    for (int i = 0; i < 16; i++) q.push_back(8'h40 + 8'(i));
    wr(8'h20, q);
    m.stop();
    m.start();
    put(8'hA0, 1'b1);
    m.stop();
    drain();
    wr(8'h2F, '{8'hC1, 8'hC2});
    m.stop();
    idle();
    q[0] = 8'hC2;
    q[15] = 8'hC1;
    rd(8'h20, q);
  endtask
  task automatic t_wp();
    wp = 1'b1;
    wr(8'h20, '{8'h55});
    m.stop();
    repeat (20) @(negedge clk);
    chk(16'(busy), 16'h0);
    rd(8'h20, '{8'hC2});
    wr(8'h30, '{8'h66});
    wp = 1'b0;  // Level counts at commit only
    m.stop();
    idle();
    rd(8'h30, '{8'h66});
  endtask
  // Reset in mid-programming must drop busy and leave standby
  task automatic t_abort();
    wr(8'h31, '{8'h77});
    m.stop();
    repeat (20) if (busy !== 1'b1) @(negedge clk);
    chk(16'(busy), 16'h1);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(busy), 16'h0);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    m.start();
    put(8'hA0, 1'b0);
    m.stop();
  endtask

  // Hang guard well above the expected length of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_select();
    t_page();
    t_wp();
    t_abort();
    finish_test();
  end
endmodule
